/* rtl/interrupt_vector_priority.sv */
// Interrupt unit: pending and enable registers, priority pick, vector output, APB slave
`timescale 1ns/1ps
`include "ivp_regs.svh"
module interrupt_vector_priority (
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst_n,
    // APB slave
    input  wire logic                 i_psel,
    input  wire logic                 i_penable,
    input  wire logic                 i_pwrite,
    input  wire logic [11:0]          i_paddr,
    input  wire logic [31:0]          i_pwdata,
    output logic      [31:0]          o_prdata,
    output logic                      o_pready,
    output logic                      o_pslverr,
    // Peripheral requests
    input  wire logic                 i_nmi_request,
    input  wire logic                 i_external_pin_request,
    input  wire logic                 i_network_request,
    input  wire logic                 i_serial_receive_request,
    input  wire logic                 i_serial_transmit_request,
    input  wire logic                 i_sync_serial_channel_one,
    input  wire logic                 i_sync_serial_channel_zero,
    input  wire logic                 i_command_buffer_full,
    input  wire logic                 i_input_buffer_full,
    input  wire logic                 i_output_buffer_empty,
    input  wire logic                 i_convert_done,
    input  wire logic [3:0]           i_capture_compare_request,
    input  wire logic [19:0]          i_capture_compare_shared_request,
    // Core vector handshake
    output logic                      o_vec_valid,
    output logic      [23:0]          o_vec_addr,
    output logic      [4:0]           o_vec_prio,
    output logic      [3:0]           o_vec_src,
    output logic                      o_vec_service,
    input  wire logic                 i_vec_ack,
    // Event interrupt
    output logic                      o_irq
);
    ivp_pick_if bus ();

    logic [15:0]            pend_q;
    logic [15:0]            pend_d;
    logic [15:0]            mask_q;
    logic [15:0]            svc_sel_q;
    logic                   gie_q;
    logic [15:0]            enable_eff;
    logic                   take;
    logic [15:0]            take_clr;
    logic [7:0]             idx;
    logic                   setup;
    logic                   access_done;
    logic                   wr_done;
    logic                   rd_done;
    logic                   mapped;
    logic [31:0]            rdata_d;
    logic [31:0]            prdata_q;
    logic                   slverr_q;
    logic [`EVT_WIDTH-1:0]  evt_q;
    logic [`EVT_WIDTH-1:0]  evt_mask_q;
    logic [`EVT_WIDTH-1:0]  evt_set;
    logic                   vec_valid_q;
    ivp_pkg::vec_t          vec_addr_q;
    ivp_pkg::prio_t         vec_prio_q;
    ivp_pkg::src_t          vec_src_q;
    logic                   vec_svc_q;

    ivp_request_merge u_merge (
        .i_mclk                           (i_mclk),
        .i_rst_n                          (i_rst_n),
        .i_nmi_request                    (i_nmi_request),
        .i_external_pin_request           (i_external_pin_request),
        .i_network_request                (i_network_request),
        .i_serial_receive_request         (i_serial_receive_request),
        .i_serial_transmit_request        (i_serial_transmit_request),
        .i_sync_serial_channel_one        (i_sync_serial_channel_one),
        .i_sync_serial_channel_zero       (i_sync_serial_channel_zero),
        .i_command_buffer_full            (i_command_buffer_full),
        .i_input_buffer_full              (i_input_buffer_full),
        .i_output_buffer_empty            (i_output_buffer_empty),
        .i_convert_done                   (i_convert_done),
        .i_capture_compare_request        (i_capture_compare_request),
        .i_capture_compare_shared_request (i_capture_compare_shared_request),
        .bus                              (bus)
    );

    ivp_priority_pick u_pick (
        .bus (bus)
    );

    // APB decode; index is the word address
    assign idx         = i_paddr[9:2];
    assign setup       = i_psel && !i_penable;
    assign access_done = i_psel && i_penable;
    assign wr_done     = access_done && i_pwrite && !slverr_q;
    assign rd_done     = access_done && !i_pwrite && !slverr_q;
    assign o_pready    = access_done;
    assign o_prdata    = prdata_q;
    assign o_pslverr   = access_done && slverr_q;

    // Function of the index, used for both decode and read data
    function automatic logic is_mapped(input logic [7:0] a, input logic [11:0] full);
        logic ok;
        ok = (full[1:0] == 2'b00) && (full[11:10] == 2'b00) &&
             (a >= `IDX_PEND_LOWER) && (a <= `IDX_EVT_MASK);
        return ok;
    endfunction : is_mapped

    assign mapped = is_mapped(idx, i_paddr);

    // The non-maskable enable bit is tied on whatever software writes
    assign enable_eff = {1'b1, mask_q[14:0]};

    // Candidates: pending, enabled, and global enable unless non-maskable
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            bus.active[i] = pend_q[i] && enable_eff[i] &&
                            (gie_q || (i == 15));
        end
    end

    // Non-maskable has no service form
    assign bus.svc_sel = {1'b0, svc_sel_q[14:0]};

    // Vector taken by the core clears the latched source
    assign take     = i_vec_ack && vec_valid_q;
    assign take_clr = take ? (16'h0001 << vec_src_q) : 16'h0000;

    // Pending register; a new detection wins over both clears
    always_comb begin
        pend_d = pend_q & ~take_clr;
        if (wr_done && (idx == `IDX_PEND_LOWER)) begin
            pend_d[7:0] = i_pwdata[7:0];
        end
        if (wr_done && (idx == `IDX_PEND_UPPER)) begin
            pend_d[15:8] = i_pwdata[7:0];
        end
        pend_d = pend_d | bus.req;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            pend_q <= {`RST_PEND, `RST_PEND};
        end else begin
            pend_q <= pend_d;
        end
    end

    // Enable, service select and control registers steer the pick
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            mask_q    <= {`RST_MASK, `RST_MASK};
            svc_sel_q <= `RST_SERVICE_SEL;
            gie_q     <= `RST_CONTROL;
        end else if (wr_done) begin
            if (idx == `IDX_MASK_LOWER) begin
                mask_q[7:0] <= i_pwdata[7:0];
            end
            if (idx == `IDX_MASK_UPPER) begin
                mask_q[15:8] <= i_pwdata[7:0];
            end
            if (idx == `IDX_SERVICE_SEL) begin
                svc_sel_q <= i_pwdata[15:0];
            end
            if (idx == `IDX_CONTROL) begin
                gie_q <= i_pwdata[0];
            end
        end
    end

    // Vector output; dropped for one cycle after a take so a stale pick is not reused
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            vec_valid_q <= 1'b0;
            vec_addr_q  <= 24'h000000;
            vec_prio_q  <= 5'h00;
            vec_src_q   <= 4'h0;
            vec_svc_q   <= 1'b0;
        end else begin
            vec_valid_q <= bus.found && !take;
            vec_addr_q  <= ivp_pkg::vec_of(bus.src, bus.use_svc);
            vec_prio_q  <= bus.prio;
            vec_src_q   <= bus.src;
            vec_svc_q   <= bus.use_svc;
        end
    end

    assign o_vec_valid   = vec_valid_q;
    assign o_vec_addr    = vec_addr_q;
    assign o_vec_prio    = vec_prio_q;
    assign o_vec_src     = vec_src_q;
    assign o_vec_service = vec_svc_q;

    // Events: taken vector, request lost on a set bit, source 0 or 13 taken in service form
    assign evt_set[`EVT_TAKEN]      = take;
    assign evt_set[`EVT_LOST]       = |(bus.req & pend_q & ~take_clr);
    assign evt_set[`EVT_SHARED_SVC] = take && vec_svc_q &&
                                      ((vec_src_q == `SRC_SLOT_ZERO) ||
                                       (vec_src_q == `SRC_SLOT_THIRTEEN));

    // Sticky status; a read clears only the bits it showed, so an event during setup survives
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            evt_q <= '0;
        end else if (rd_done && (idx == `IDX_EVT_STATUS)) begin
            evt_q <= (evt_q & ~prdata_q[`EVT_WIDTH-1:0]) | evt_set;
        end else begin
            evt_q <= evt_q | evt_set;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            evt_mask_q <= '0;
        end else if (wr_done && (idx == `IDX_EVT_MASK)) begin
            evt_mask_q <= i_pwdata[`EVT_WIDTH-1:0];
        end
    end

    assign o_irq = |(evt_q & evt_mask_q);

    // Read data, captured in the setup cycle so it comes from a flip-flop
    always_comb begin
        rdata_d = 32'h00000000;
        unique case (idx)
            `IDX_PEND_LOWER:  rdata_d[7:0]  = pend_q[7:0];
            `IDX_MASK_LOWER:  rdata_d[7:0]  = mask_q[7:0];
            `IDX_PEND_UPPER:  rdata_d[7:0]  = pend_q[15:8];
            `IDX_MASK_UPPER:  rdata_d[7:0]  = mask_q[15:8];
            `IDX_SERVICE_SEL: rdata_d[15:0] = svc_sel_q;
            `IDX_CONTROL:     rdata_d[0]    = gie_q;
            `IDX_VECTOR:      rdata_d = {vec_valid_q, 1'b0, vec_svc_q, vec_prio_q, vec_addr_q};
            `IDX_EVT_STATUS:  rdata_d[`EVT_WIDTH-1:0] = evt_q;
            `IDX_EVT_MASK:    rdata_d[`EVT_WIDTH-1:0] = evt_mask_q;
            default:          rdata_d = 32'h00000000;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            prdata_q <= 32'h00000000;
            slverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= mapped ? rdata_d : 32'h00000000;
            slverr_q <= !mapped;
        end
    end

    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    sequence s_vec_of(logic [3:0] s);
        o_vec_valid && (o_vec_src == s);
    endsequence

    sequence s_nmi_waiting;
        pend_q[15] && !take;
    endsequence

    a_slot13_vector: assert property (s_vec_of(`SRC_SLOT_THIRTEEN) |->
        (o_vec_service ? (o_vec_addr == `VEC_SLOT13_SVC && o_vec_prio == 5'd28)
                       : (o_vec_addr == `VEC_SLOT13_STD && o_vec_prio == 5'd13)))
        else $error("slot thirteen vector or level wrong");

    a_nmi_top_level: assert property (s_nmi_waiting |=>
        o_vec_valid && o_vec_src == `SRC_NONMASKABLE && o_vec_prio == `PRIO_NONMASKABLE
        && !o_vec_service)
        else $error("non-maskable request not vectored at top level");

    a_cmd_full_vec: assert property (s_vec_of(`SRC_COMMAND_FULL) |->
        (o_vec_service ? (o_vec_addr == `VEC_SLOT8_SVC && o_vec_prio == 5'd23)
                       : (o_vec_addr == `VEC_SLOT8_STD && o_vec_prio == 5'd8)))
        else $error("command buffer full vector wrong");

    a_in_full_vec: assert property (s_vec_of(`SRC_INPUT_FULL) |->
        (o_vec_service ? (o_vec_addr == `VEC_SLOT7_SVC && o_vec_prio == 5'd22)
                       : (o_vec_addr == `VEC_SLOT7_STD && o_vec_prio == 5'd7)))
        else $error("input buffer full vector wrong");

    a_out_empty_vec: assert property (s_vec_of(`SRC_OUTPUT_EMPTY) |->
        (o_vec_service ? (o_vec_addr == `VEC_SLOT6_SVC && o_vec_prio == 5'd21)
                       : (o_vec_addr == `VEC_SLOT6_STD && o_vec_prio == 5'd6)))
        else $error("output buffer empty vector wrong");

    a_slot0_vector: assert property (s_vec_of(`SRC_SLOT_ZERO) && !o_vec_service |->
        o_vec_addr == `VEC_SLOT0_STD && o_vec_prio == 5'd0)
        else $error("slot zero vector wrong");

    a_service_band: assert property (o_vec_valid && o_vec_service |->
        o_vec_prio >= `PRIO_SERVICE_BASE && o_vec_prio <= `PRIO_SERVICE_TOP &&
        o_vec_addr == `VEC_SVC_BASE + {19'h00000, o_vec_src, 1'b0})
        else $error("service level outside its band");

    a_sync1_vector: assert property (s_vec_of(`SRC_SYNC_ONE) |->
        (o_vec_service ? o_vec_addr == `VEC_SYNC1_SVC : o_vec_addr == `VEC_SYNC1_STD))
        else $error("sync serial one vector wrong");

    a_enable_gate: assert property (bus.found |->
        enable_eff[bus.src] && pend_q[bus.src])
        else $error("disabled or idle source picked");

    a_pend_set: assert property ((bus.req != 16'h0000) |=>
        ((pend_q & $past(bus.req)) == $past(bus.req)))
        else $error("detected request not pending");

    a_take_clear: assert property (take && !bus.req[vec_src_q] && !wr_done |=>
        !pend_q[$past(vec_src_q)] ##1 !o_vec_valid || o_vec_src != $past(vec_src_q, 2)
        || pend_q[$past(vec_src_q, 2)])
        else $error("taken vector not cleared");

    a_gie_gate: assert property (!gie_q && !pend_q[15] |=> !o_vec_valid)
        else $error("vector while globally disabled");

    a_apb_err: assert property (setup && !mapped ##1 access_done |-> o_pslverr)
        else $error("unmapped access not flagged");
endmodule : interrupt_vector_priority

/* rtl/ivp_regs.svh */
// Register indices, field positions, reset values and vector constants of the interrupt unit
`ifndef IVP_REGS_SVH
`define IVP_REGS_SVH

// Register indices; the byte address on the bus is four times the index
`define IDX_PEND_LOWER      8'h10
`define IDX_MASK_LOWER      8'h11
`define IDX_PEND_UPPER      8'h12
`define IDX_MASK_UPPER      8'h13
`define IDX_SERVICE_SEL     8'h14
`define IDX_CONTROL         8'h15
`define IDX_VECTOR          8'h16
`define IDX_EVT_STATUS      8'h17
`define IDX_EVT_MASK        8'h18

// Reset values
`define RST_PEND            8'h00
`define RST_MASK            8'h00
`define RST_SERVICE_SEL     16'h0000
`define RST_CONTROL         1'b0

// Source numbers
`define SRC_SLOT_ZERO       4'h0
`define SRC_OUTPUT_EMPTY    4'h6
`define SRC_INPUT_FULL      4'h7
`define SRC_COMMAND_FULL    4'h8
`define SRC_SYNC_ONE        4'ha
`define SRC_SLOT_THIRTEEN   4'hd
`define SRC_NONMASKABLE     4'hf

// Priorities and vector bases
`define PRIO_NONMASKABLE    5'h1e
`define PRIO_SERVICE_BASE   5'h0f
`define PRIO_SERVICE_TOP    5'h1d
`define VEC_STD_BASE        24'hff2000
`define VEC_SVC_BASE        24'hff2040

// Vectors of individual sources, used to check the vector arithmetic
`define VEC_SLOT13_STD      24'hff203a
`define VEC_SLOT13_SVC      24'hff205a
`define VEC_SLOT8_STD       24'hff2030
`define VEC_SLOT8_SVC       24'hff2050
`define VEC_SLOT7_STD       24'hff200e
`define VEC_SLOT7_SVC       24'hff204e
`define VEC_SLOT6_STD       24'hff200c
`define VEC_SLOT6_SVC       24'hff204c
`define VEC_SLOT0_STD       24'hff2000
`define VEC_SYNC1_STD       24'hff2034
`define VEC_SYNC1_SVC       24'hff2054

// Event status bits
`define EVT_TAKEN           0
`define EVT_LOST            1
`define EVT_SHARED_SVC      2
`define EVT_WIDTH           3

`endif

/* rtl/ivp_pkg.sv */
// Types and vector arithmetic shared by the interrupt unit
`include "ivp_regs.svh"
package ivp_pkg;
    typedef logic [3:0]  src_t;
    typedef logic [4:0]  prio_t;
    typedef logic [23:0] vec_t;

    // Priority level of a source, standard or transaction service
    function automatic prio_t prio_of(input src_t s, input logic svc);
        prio_t p;
        p = {1'b0, s};
        if (s == `SRC_NONMASKABLE) begin
            p = `PRIO_NONMASKABLE;
        end else if (svc) begin
            p = `PRIO_SERVICE_BASE + {1'b0, s};
        end
        return p;
    endfunction : prio_of

    // Vector address of a source, standard or transaction service
    // Standard table leaves a gap after source seven, so sources eight up sit 20h higher
    function automatic vec_t vec_of(input src_t s, input logic svc);
        vec_t v;
        if (svc && (s != `SRC_NONMASKABLE)) begin
            v = `VEC_SVC_BASE + {19'h00000, s, 1'b0};
        end else begin
            v = `VEC_STD_BASE + {18'h00000, s[3], s, 1'b0};
        end
        return v;
    endfunction : vec_of
endpackage : ivp_pkg

/* rtl/ivp_pick_if.sv */
// Signals between the request merger, the priority picker and the core of the unit
`timescale 1ns/1ps
interface ivp_pick_if;
    logic [15:0]   req;
    logic [15:0]   active;
    logic [15:0]   svc_sel;
    logic          found;
    ivp_pkg::src_t src;
    ivp_pkg::prio_t prio;
    logic          use_svc;

    modport merge  (output req);
    modport picker (input active, input svc_sel, output found, output src, output prio,
                    output use_svc);
    modport core   (input req, output active, output svc_sel, input found, input src,
                    input prio, input use_svc);
endinterface : ivp_pick_if

/* rtl/ivp_request_merge.sv */
// Edge detection of peripheral requests and merging of the shared slot-zero sources
`timescale 1ns/1ps
module ivp_request_merge (
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic        i_nmi_request,
    input  wire logic        i_external_pin_request,
    input  wire logic        i_network_request,
    input  wire logic        i_serial_receive_request,
    input  wire logic        i_serial_transmit_request,
    input  wire logic        i_sync_serial_channel_one,
    input  wire logic        i_sync_serial_channel_zero,
    input  wire logic        i_command_buffer_full,
    input  wire logic        i_input_buffer_full,
    input  wire logic        i_output_buffer_empty,
    input  wire logic        i_convert_done,
    input  wire logic [3:0]  i_capture_compare_request,
    input  wire logic [19:0] i_capture_compare_shared_request,
    ivp_pick_if.merge        bus
);
    logic [14:1] level;
    logic [15:1] prev_q;
    logic [19:0] shared_prev_q;
    logic [19:0] shared_rise;
    logic        nmi_rise;

    // Request levels by source number; channel 0 ranks above channel 3
    assign level = {i_external_pin_request, i_network_request, i_serial_receive_request,
                    i_serial_transmit_request, i_sync_serial_channel_one,
                    i_sync_serial_channel_zero, i_command_buffer_full,
                    i_input_buffer_full, i_output_buffer_empty, i_convert_done,
                    i_capture_compare_request[0], i_capture_compare_request[1],
                    i_capture_compare_request[2], i_capture_compare_request[3]};

    // Previous levels, so that a held request is seen once
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            prev_q        <= 15'h0000;
            shared_prev_q <= 20'h00000;
        end else begin
            prev_q        <= {i_nmi_request, level};
            shared_prev_q <= i_capture_compare_shared_request;
        end
    end

    // Per-bit edges of the shared group, so a held bit does not mask a new one
    assign shared_rise = i_capture_compare_shared_request & ~shared_prev_q;
    assign nmi_rise    = i_nmi_request & ~prev_q[15];

    // One-cycle detection pulses per source
    assign bus.req = {nmi_rise, level & ~prev_q[14:1], |shared_rise};

    a_shared_merge: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (shared_rise != 20'h00000) |-> bus.req[0])
        else $error("shared edge not merged into slot zero");
endmodule : ivp_request_merge

/* rtl/ivp_priority_pick.sv */
// Fixed-priority selection among active requests
`timescale 1ns/1ps
module ivp_priority_pick (
    ivp_pick_if.picker bus
);
    // Highest level wins; ties cannot occur since each level has one owner
    always_comb begin
        bus.found   = 1'b0;
        bus.src     = 4'h0;
        bus.prio    = 5'h00;
        bus.use_svc = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (bus.active[i] && (!bus.found ||
                ivp_pkg::prio_of(4'(i), bus.svc_sel[i]) > bus.prio)) begin
                bus.found   = 1'b1;
                bus.src     = 4'(i);
                bus.prio    = ivp_pkg::prio_of(4'(i), bus.svc_sel[i]);
                bus.use_svc = bus.svc_sel[i];
            end
        end
    end
endmodule : ivp_priority_pick

/* bench/ivp_core_model.sv */
// Core-side model that takes each offered vector after a set delay
`timescale 1ns/1ps
module ivp_core_model (
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic        i_hold,
    input  wire logic [3:0]  i_delay,
    input  wire logic        i_vec_valid,
    input  wire logic [28:0] i_vec,
    output logic             o_vec_ack,
    output logic      [28:0] o_last,
    output logic      [7:0]  o_taken
);
    logic [3:0] wait_q;

    // One ack per offer; a held core leaves requests pending
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_vec_ack <= 1'b0;
            wait_q <= 4'h0;
            o_taken <= 8'h00;
            o_last <= 29'h0;
        end else if (o_vec_ack) begin
            o_vec_ack <= 1'b0;
            wait_q <= 4'h0;
            o_taken <= o_taken + 8'h01;
            o_last <= i_vec; // Vector as it stood at the taking edge
        end else if (i_vec_valid && !i_hold) begin
            o_vec_ack <= (wait_q >= i_delay);
            wait_q <= wait_q + 4'h1;
        end else begin
            wait_q <= 4'h0;
        end
    end
endmodule : ivp_core_model

/* bench/interrupt_vector_priority_bench.sv */
// Register and vector bench of the interrupt unit
`timescale 1ns/1ps
module interrupt_vector_priority_bench;
    logic i_mclk = 1'b0, i_rst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
    logic o_pready, o_pslverr, o_vec_valid, o_vec_service, ack, o_irq, err, hold = 1'b0;
    logic [23:0] o_vec_addr;
    logic [4:0] o_vec_prio;
    logic [3:0] o_vec_src, dly = 4'h0;
    logic [15:0] rq = 16'h0000;
    logic [28:0] last;
    logic [7:0] taken, seen = 8'h00;
    int bad_count = 0, checks_done = 0;
    // Sources 13, 8, 7, 6, 10, 0 with {level, vector}
    int src_n [6] = '{13, 8, 7, 6, 10, 0};
    logic [28:0] std_v [6] = '{{5'h0d, 24'hff203a}, {5'h08, 24'hff2030}, {5'h07, 24'hff200e},
        {5'h06, 24'hff200c}, {5'h0a, 24'hff2034}, {5'h00, 24'hff2000}};
    logic [28:0] svc_v [5] = '{{5'h1c, 24'hff205a}, {5'h17, 24'hff2050}, {5'h16, 24'hff204e},
        {5'h15, 24'hff204c}, {5'h19, 24'hff2054}};

    interrupt_vector_priority interrupt_vector_priority_inst (
        .i_mclk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
        .o_pready, .o_pslverr, .i_nmi_request(rq[15]), .i_external_pin_request(rq[14]),
        .i_network_request(rq[13]), .i_serial_receive_request(rq[12]),
        .i_serial_transmit_request(rq[11]), .i_sync_serial_channel_one(rq[10]),
        .i_sync_serial_channel_zero(rq[9]), .i_command_buffer_full(rq[8]),
        .i_input_buffer_full(rq[7]), .i_output_buffer_empty(rq[6]), .i_convert_done(rq[5]),
        .i_capture_compare_request({rq[1], rq[2], rq[3], rq[4]}),
        .i_capture_compare_shared_request({12'h000, rq[0], 7'h00}), .o_vec_valid,
        .o_vec_addr, .o_vec_prio, .o_vec_src, .o_vec_service, .i_vec_ack(ack), .o_irq);
    ivp_core_model ivp_core_model_inst (
        .i_mclk, .i_rst_n, .i_hold(hold), .i_delay(dly), .i_vec_valid(o_vec_valid),
        .i_vec({o_vec_prio, o_vec_addr}), .o_vec_ack(ack), .o_last(last), .o_taken(taken));

    // Core clock, 25 ns period
    always #12.5 i_mclk = ~i_mclk;

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h, expected %h", $time, g, e);
        end
    endtask : chk

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge i_mclk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= {2'b00, idx, 2'b00};
        i_pwdata <= d;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        @(posedge i_mclk);
        while (o_pready !== 1'b1) begin
            @(posedge i_mclk);
        end
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    task automatic pulse(input logic [15:0] m);
        @(posedge i_mclk);
        rq <= m;
        repeat (2) @(posedge i_mclk);
        rq <= 16'h0000;
    endtask : pulse

    // Waits for the core model's next taken vector; a hang is left to the watchdog
    task automatic take(input logic [28:0] e);
        seen++;
        while (taken !== seen) begin
            @(posedge i_mclk);
        end
        chk({3'b000, last}, {3'b000, e});
    endtask : take

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    // Main sequence
    initial begin
        repeat (3) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        apb(1'b0, 8'h12, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h13, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h30, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset done");
        apb(1'b1, 8'h11, 32'hff);
        apb(1'b1, 8'h13, 32'hff);
        apb(1'b1, 8'h15, 32'h1);
        for (int i = 0; i < 6; i++) begin
            pulse(16'h0001 << src_n[i]);
            take(std_v[i]);
        end
        dly <= 4'h3;
        apb(1'b1, 8'h14, 32'h25c0);
        for (int i = 0; i < 5; i++) begin
            pulse(16'h0001 << src_n[i]);
            take(svc_v[i]);
        end
        $display("test vectors done");
        // Three requests at once while the core holds off
        hold <= 1'b1;
        apb(1'b1, 8'h14, 32'h0040);
        pulse(16'h2140);
        apb(1'b0, 8'h12, 32'h0);
        chk(rd, 32'h21);
        hold <= 1'b0;
        take({5'h15, 24'hff204c});
        take(std_v[0]);
        take(std_v[1]);
        apb(1'b0, 8'h12, 32'h0);
        chk(rd, 32'h0);
        $display("test priority done");
        apb(1'b1, 8'h15, 32'h0);
        apb(1'b1, 8'h13, 32'h7e);
        pulse(16'h0180);
        repeat (12) @(posedge i_mclk);
        chk({24'h0, taken}, {24'h0, seen});
        pulse(16'h8000);
        take({5'h1e, 24'hff203e});
        apb(1'b1, 8'h15, 32'h1);
        take(std_v[2]);
        apb(1'b0, 8'h12, 32'h0);
        chk(rd, 32'h01);
        apb(1'b1, 8'h13, 32'hff);
        take(std_v[1]);
        $display("test enables done");
        apb(1'b1, 8'h18, 32'h1);
        @(posedge i_mclk);
        chk({31'h0, o_irq}, 32'h1);
        apb(1'b0, 8'h17, 32'h0);
        chk(rd, 32'h5);
        @(posedge i_mclk);
        chk({31'h0, o_irq}, 32'h0);
        $display("test event interrupt done");
        print_verdict();
    end

    // Watchdog; the sequence needs well under 3000 cycles
    initial begin
        repeat (5000) @(posedge i_mclk);
        bad_count++;
        print_verdict();
    end
endmodule : interrupt_vector_priority_bench
